// ===== rtl/pldac_map.svh
// Purpose: offsets, field positions, reset values and counts of the dual
//          pulse-length dac
// Assumes: clk is the cpu clock, 100 MHz
// Notes:   macros only, included by bare name
// Overview of operation
// - two independent modulated outputs, each with its own 8-bit duty register
// - period is 4096 timer clocks when slow, 256 when fast
// - timer clock is 4 cpu clocks, or 64 with system slow speed set
// - duty zero keeps the output low the whole period
// - duty n gives n/256 high; 0xFF is high 255 of 256 slots
// - duty writes are buffered and taken only at the period end
// - speed bit one selects slow period, zero selects fast, per channel
// - speed bits act at once; software sets them before duty writes
// - both speeds keep 256 slots of 8-bit resolution
// - 256 fast or 16 slow periods fit each timer overflow interval
// - phase comes from the shared timer counter; its reset disturbs outputs
// - reset clears both duty registers, outputs go low
// - entering halt freezes each output at its present level
// - leaving halt resumes modulation with held register values
// - idle mode has no effect on the modulator
// - system slow speed is cleared by reset and on entering halt
// - channel a speed at bit 3, channel b speed at bit 2 of misc
`ifndef PLDAC_MAP_SVH
`define PLDAC_MAP_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define PLDAC_OFS_DUTY_A 8'h0A
`define PLDAC_OFS_DUTY_B 8'h0B
`define PLDAC_OFS_MISC 8'h0C
// ----------------------------------------
// misc register fields
// ----------------------------------------
`define PLDAC_BIT_SPEED_A 3
`define PLDAC_BIT_SPEED_B 2
`define PLDAC_BIT_SLOW 1
// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define PLDAC_DUTY_RST 8'h00
`define PLDAC_PRESC_NORM 7'h04
`define PLDAC_PRESC_SLOW 7'h40
`define PLDAC_FAST_END 12'h0FF
`define PLDAC_SLOW_END 12'hFFF
`endif

// ===== rtl/pldac_pkg.sv
// Purpose: types shared by the pulse-length dac files
// Assumes: constants live in pldac_map.svh
// Notes:   state of each module is one packed struct
package pldac_pkg;
   typedef enum logic [0:0] {
      PLDAC_PWR_RUN = 1'b0,
      PLDAC_PWR_HALT = 1'b1
   } pldac_pwr_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } pldac_bus_t;

   typedef struct packed {
      logic [6:0] presc;
      logic [15:0] tcnt;
   } pldac_tb_st_t;

   typedef struct packed {
      logic [7:0] buffer;
      logic [7:0] active;
      logic out;
   } pldac_ch_st_t;

   typedef struct packed {
      pldac_pwr_t pwr;
      logic speed_a;
      logic speed_b;
      logic slow;
      logic [7:0] rdata;
   } pldac_top_st_t;
endpackage

// ===== rtl/pldac_timebase.sv
// Purpose: timer clock prescaler and shared free-running timer counter
// Assumes: halt stops the timer, idle does not reach here
// Notes:   tick is a one-cycle enable, the only slow rate
`timescale 1ns/1ps
`include "pldac_map.svh"
module pldac_timebase (
   input wire logic clk,
   input wire logic rstn,
   input wire logic slow,
   input wire logic halt,
   input wire logic tmr_rst,
   output logic tick,
   output logic [15:0] tcnt
);
   pldac_pkg::pldac_tb_st_t st, next_st;
   logic [6:0] limit;

   // ----------------------------------------
   // prescaler and counter
   // ----------------------------------------
   // limit follows slow at once so a mode change takes effect next tick
   always_comb begin
      limit = slow ? `PLDAC_PRESC_SLOW : `PLDAC_PRESC_NORM;
      tick = !halt && (st.presc == limit - 7'h01);
      next_st = st;
      if (tmr_rst) begin
         next_st = '0;
      end else if (!halt) begin
         next_st.presc = tick ? 7'h00 : st.presc + 7'h01;
         if (tick) begin
            next_st.tcnt = st.tcnt + 16'h0001; // 16-bit wrap holds whole periods
         end
         if (st.presc >= limit) begin
            next_st.presc = 7'h00; // leftover from a slow to fast switch
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign tcnt = st.tcnt;

   // spacing of ticks at normal speed
   a_tick_spacing: assert property (@(posedge clk) disable iff (!rstn)
      (tick && !slow && !tmr_rst) ##1 (!slow && !halt && !tmr_rst)[*3] |=> (tick || halt || slow))
      else $error("tick spacing not four clocks");
endmodule

// ===== rtl/pldac_channel.sv
// Purpose: one modulator channel with double-buffered duty value
// Assumes: tcnt and tick come from the shared timebase
// Notes:   output is registered, one clock behind the slot
`timescale 1ns/1ps
`include "pldac_map.svh"
module pldac_channel #(
   parameter int DUTY_W = 8
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic tick,
   input wire logic [15:0] tcnt,
   input wire logic speed_slow,
   input wire logic halt,
   input wire logic wr,
   input wire logic [DUTY_W-1:0] wdata,
   output logic [DUTY_W-1:0] duty,
   output logic pwm_out
);
   pldac_pkg::pldac_ch_st_t st, next_st;
   logic [7:0] slot;
   logic period_end;

   // ----------------------------------------
   // slot and period end
   // ----------------------------------------
   // slow mode uses upper bits so both speeds keep 256 slots
   always_comb begin
      slot = speed_slow ? tcnt[11:4] : tcnt[7:0];
      period_end = tick && (speed_slow ? (tcnt[11:0] == `PLDAC_SLOW_END)
                                       : (tcnt[11:0] & `PLDAC_FAST_END) == `PLDAC_FAST_END);
      next_st = st;
      if (wr) begin
         next_st.buffer = wdata;
      end
      if (period_end) begin
         next_st.active = wr ? wdata : st.buffer;
      end
      if (!halt) begin // halt holds the last level
         next_st.out = slot < st.active;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign duty = st.buffer;
   assign pwm_out = st.out;

   a_zero_low: assert property (@(posedge clk) disable iff (!rstn)
      (st.active == 8'h00 && !halt) |=> !pwm_out)
      else $error("zero duty drove output high");
   a_full_high: assert property (@(posedge clk) disable iff (!rstn)
      (st.active == 8'hFF && slot != 8'hFF && !halt) |=> pwm_out)
      else $error("full duty not high");
   a_load_end: assert property (@(posedge clk) disable iff (!rstn)
      (st.active != $past(st.active)) |-> $past(period_end))
      else $error("active duty changed mid period");
   a_wrap_aligned: assert property (@(posedge clk) disable iff (!rstn)
      (tick && tcnt == 16'hFFFF) |-> period_end)
      else $error("period not aligned to timer overflow");
endmodule

// ===== rtl/pldac_top.sv
// Purpose: dual pulse-length dac, register port and low-power handling
// Assumes: clk is the cpu clock; halt and idle are levels from the core
// Notes:   misc bits other than speed and slow read as zero here
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "pldac_map.svh"
module pldac_top (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic halt,
   input wire logic idle,
   input wire logic tmr_rst,
   output logic [15:0] timer_count,
   output logic system_slow_speed,
   output logic modulator_channel_a,
   output logic modulator_channel_b
);
   pldac_pkg::pldac_top_st_t st, next_st;
   pldac_pkg::pldac_bus_t bus;
   logic tick;
   logic [15:0] tcnt;
   logic wr_a, wr_b, wr_misc;
   logic [7:0] duty_a, duty_b;
   logic halt_entry;
   logic idle_unused;

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
   assign wr_a = bus.wr && bus.addr == `PLDAC_OFS_DUTY_A;
   assign wr_b = bus.wr && bus.addr == `PLDAC_OFS_DUTY_B;
   assign wr_misc = bus.wr && bus.addr == `PLDAC_OFS_MISC;
   // idle is accepted and deliberately ignored
   assign idle_unused = idle;
   assign halt_entry = halt && st.pwr == pldac_pkg::PLDAC_PWR_RUN;

   // ----------------------------------------
   // control state
   // ----------------------------------------
   // speed bits are not buffered, so they bite mid period
   always_comb begin
      next_st = st;
      next_st.pwr = halt ? pldac_pkg::PLDAC_PWR_HALT : pldac_pkg::PLDAC_PWR_RUN;
      if (wr_misc) begin
         next_st.speed_a = bus.wdata[`PLDAC_BIT_SPEED_A];
         next_st.speed_b = bus.wdata[`PLDAC_BIT_SPEED_B];
         next_st.slow = bus.wdata[`PLDAC_BIT_SLOW];
      end
      if (halt_entry) begin
         next_st.slow = 1'b0; // halt wins over a same-cycle write
      end
      next_st.rdata = 8'h00;
      if (bus.rd) begin
         case (bus.addr)
            `PLDAC_OFS_DUTY_A: next_st.rdata = duty_a;
            `PLDAC_OFS_DUTY_B: next_st.rdata = duty_b;
            `PLDAC_OFS_MISC: begin
               next_st.rdata[`PLDAC_BIT_SPEED_A] = st.speed_a;
               next_st.rdata[`PLDAC_BIT_SPEED_B] = st.speed_b;
               next_st.rdata[`PLDAC_BIT_SLOW] = st.slow;
            end
            default: next_st.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         st <= '0; // slow speed cleared by reset
      end else begin
         st <= next_st;
      end
   end

   assign rdata = st.rdata;
   assign system_slow_speed = st.slow;
   assign timer_count = tcnt;

   // ----------------------------------------
   // shared timebase and channels
   // ----------------------------------------
   // halt stops the timer, so outputs freeze and resume in phase
   pldac_timebase u_tb (
      .clk(clk),
      .rstn(rstn),
      .slow(st.slow),
      .halt(halt),
      .tmr_rst(tmr_rst),
      .tick(tick),
      .tcnt(tcnt)
   );

   pldac_channel #(.DUTY_W(8)) u_ch_a (
      .clk(clk),
      .rstn(rstn),
      .tick(tick),
      .tcnt(tcnt),
      .speed_slow(st.speed_a),
      .halt(halt),
      .wr(wr_a),
      .wdata(bus.wdata),
      .duty(duty_a),
      .pwm_out(modulator_channel_a)
   );

   pldac_channel #(.DUTY_W(8)) u_ch_b (
      .clk(clk),
      .rstn(rstn),
      .tick(tick),
      .tcnt(tcnt),
      .speed_slow(st.speed_b),
      .halt(halt),
      .wr(wr_b),
      .wdata(bus.wdata),
      .duty(duty_b),
      .pwm_out(modulator_channel_b)
   );

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence s_halt_entry;
      !halt ##1 halt;
   endsequence

   sequence s_halt_hold;
      halt ##1 halt;
   endsequence

   a_slow_halt_clear: assert property (@(posedge clk) disable iff (!rstn)
      s_halt_entry |=> !system_slow_speed)
      else $error("slow speed not cleared on halt");
   a_halt_freeze: assert property (@(posedge clk) disable iff (!rstn)
      s_halt_hold |=> $stable(modulator_channel_a) && $stable(modulator_channel_b))
      else $error("output moved during halt");
   a_speed_now: assert property (@(posedge clk) disable iff (!rstn)
      wr_misc |=> st.speed_a == $past(wdata[3]) && st.speed_b == $past(wdata[2]))
      else $error("speed bit not applied at once");
   a_read_duty: assert property (@(posedge clk) disable iff (!rstn)
      (rd && addr == 8'h0A) |=> rdata == $past(duty_a))
      else $error("duty a read mismatch");
   a_reset_low: assert property (@(posedge clk)
      !rstn |=> duty_a == 8'h00 && duty_b == 8'h00 && !system_slow_speed)
      else $error("reset did not clear duty registers");
   a_period_fast: assert property (@(posedge clk) disable iff (!rstn)
      (tick && tcnt[7:0] == 8'hFF && !st.speed_a) |=> tcnt[7:0] == 8'h00)
      else $error("fast period not 256 slots");

   // register reads answer one cycle after the strobe, writes land in the buffer
   sequence s_duty_b_read;
      rd && addr == `PLDAC_OFS_DUTY_B;
   endsequence

   sequence s_duty_a_write;
      wr && addr == `PLDAC_OFS_DUTY_A;
   endsequence

   a_read_duty_b: assert property (@(posedge clk) disable iff (!rstn)
      s_duty_b_read |=> rdata == $past(duty_b))
      else $error("duty b read mismatch");
   a_write_buffer: assert property (@(posedge clk) disable iff (!rstn)
      s_duty_a_write |=> duty_a == $past(wdata))
      else $error("duty a write not held in buffer");
   a_read_misc: assert property (@(posedge clk) disable iff (!rstn)
      (rd && addr == `PLDAC_OFS_MISC) |=>
         rdata == {4'h0, $past(st.speed_a), $past(st.speed_b), $past(system_slow_speed), 1'b0})
      else $error("misc read layout wrong");
   a_rdata_quiet: assert property (@(posedge clk) disable iff (!rstn)
      !rd |=> rdata == 8'h00)
      else $error("read data not cleared");
   // the timer must stand still in halt so both channels resume in phase
   a_timer_halt: assert property (@(posedge clk) disable iff (!rstn)
      (halt && !tmr_rst) |=> $stable(timer_count))
      else $error("timer ran during halt");
   a_timer_clear: assert property (@(posedge clk) disable iff (!rstn)
      tmr_rst |=> timer_count == 16'h0000)
      else $error("timer not cleared");
   a_reset_pins: assert property (@(posedge clk)
      !rstn |=> !modulator_channel_a && !modulator_channel_b)
      else $error("outputs not low after reset");
   a_speed_hold: assert property (@(posedge clk) disable iff (!rstn)
      !wr_misc |=> $stable(st.speed_a) && $stable(st.speed_b))
      else $error("speed bit changed without a write");
endmodule

// ===== dv/pldac_load.sv
// Purpose: load on the two modulator pins, a counting stand-in for an rc average
// Assumes: pins are sampled on the cpu clock
// Notes:   clr restarts both sums; an rc filter would settle far slower
`timescale 1ns/1ps
module pldac_load (
   input wire logic clk,
   input wire logic clr,
   input wire logic pin_a,
   input wire logic pin_b,
   output int hi_a,
   output int hi_b
);
   // ------------------------------
   // high-time sums
   // ------------------------------
   // a sum over one whole period equals the averaged level times the period
   always_ff @(posedge clk) begin
      if (clr) begin
         hi_a <= 0;
         hi_b <= 0;
      end else begin
         hi_a <= hi_a + int'(pin_a);
         hi_b <= hi_b + int'(pin_b);
      end
   end
endmodule

// ===== dv/testbench.sv
// Purpose: register, duty, buffering, halt and reset checks of the dac
// Assumes: clk 100 MHz, no shortened counts
// Notes:   slow channel with system slow speed is set but never measured, far too long
`timescale 1ns/1ps
`include "pldac_map.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
   $display("ERROR %s exp %0h got %0h", n, e, g); end end
module testbench;
   logic clk = 0, rstn = 0, wr = 0, rd = 0, halt = 0, idle = 0, tmr_rst = 0, clr = 0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic [15:0] timer_count, tc;
   logic sys_slow, out_a, out_b, pa;
   int hi_a, hi_b, err_total = 0, checked = 0, i;
   always #5 clk = ~clk;
   pldac_top DUT (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .halt(halt), .idle(idle), .tmr_rst(tmr_rst),
      .timer_count(timer_count), .system_slow_speed(sys_slow),
      .modulator_channel_a(out_a), .modulator_channel_b(out_b));
   pldac_load load (.clk(clk), .clr(clr), .pin_a(out_a), .pin_b(out_b),
      .hi_a(hi_a), .hi_b(hi_b));
   // ------------------------------
   // bus and measuring tasks
   // ------------------------------
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
      @(posedge clk) wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk) begin addr <= a; rd <= 1'b1; end
      @(posedge clk) rd <= 1'b0;
      #1 `CHK("rdata", e, rdata)
   endtask
   // one clr cycle, then n summed samples
   task automatic measure(input int n);
      @(posedge clk) clr <= 1'b1;
      @(posedge clk) clr <= 1'b0;
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic tick_chk(input int n, input logic [15:0] e);
      @(posedge clk) #1 tc = timer_count;
      repeat (n) @(posedge clk);
      #1 `CHK("tick", e, 16'(timer_count - tc))
   endtask
   task automatic close_out;
      if (err_total == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // watchdog sized well past the roughly 60k cycles of the sequence
   initial begin
      #1000000 err_total++;
      close_out();
   end
   // ------------------------------
   // main sequence
   // ------------------------------
   initial begin
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      rd_chk(`PLDAC_OFS_DUTY_A, 8'h00);
      rd_chk(`PLDAC_OFS_DUTY_B, 8'h00);
      rd_chk(`PLDAC_OFS_MISC, 8'h00);
      rd_chk(8'h0D, 8'h00);
      wr_reg(`PLDAC_OFS_MISC, 8'hFF);
      rd_chk(`PLDAC_OFS_MISC, 8'h0E);
      // speed bits go in before any duty write
      wr_reg(`PLDAC_OFS_MISC, 8'h0C);
      tick_chk(400, 16'd100);
      wr_reg(`PLDAC_OFS_DUTY_A, 8'hFF);
      wr_reg(`PLDAC_OFS_DUTY_B, 8'h40);
      rd_chk(`PLDAC_OFS_DUTY_A, 8'hFF);
      rd_chk(`PLDAC_OFS_DUTY_B, 8'h40);
      repeat (32768) @(posedge clk);
      idle <= 1'b1;
      measure(16384);
      `CHK("hi_a", 16320, hi_a)
      `CHK("hi_b", 4096, hi_b)
      @(posedge clk) idle <= 1'b0;
      wr_reg(`PLDAC_OFS_MISC, 8'h06);
      tick_chk(640, 16'd10);
      for (i = 0; i < 4000 && out_a !== 1'b1; i++) @(posedge clk) #1;
      @(posedge clk) halt <= 1'b1;
      repeat (3) @(posedge clk);
      #1 pa = out_a;
      tc = timer_count;
      repeat (500) @(posedge clk);
      #1 `CHK("frozen", pa, out_a)
      `CHK("timer_held", tc, timer_count)
      `CHK("sys_slow", 1'b0, sys_slow)
      @(posedge clk) halt <= 1'b0;
      wr_reg(`PLDAC_OFS_MISC, 8'h00);
      tick_chk(400, 16'd100);
      wr_reg(`PLDAC_OFS_DUTY_A, 8'h80);
      repeat (2048) @(posedge clk);
      measure(1024);
      `CHK("hi_a", 512, hi_a)
      `CHK("hi_b", 256, hi_b)
      // a write in mid-period must not cut the running pulse short
      for (i = 0; i < 2000 && timer_count[7:0] !== 8'h40; i++) @(posedge clk) #1;
      wr_reg(`PLDAC_OFS_DUTY_A, 8'h00);
      repeat (2) @(posedge clk);
      #1 `CHK("buffered", 1'b1, out_a)
      repeat (2048) @(posedge clk);
      measure(1024);
      `CHK("hi_a", 0, hi_a)
      @(posedge clk) tmr_rst <= 1'b1;
      repeat (2) @(posedge clk);
      #1 `CHK("tmr_rst", 16'h0000, timer_count)
      @(posedge clk) tmr_rst <= 1'b0;
      @(posedge clk) rstn <= 1'b0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      #1 `CHK("out_b", 1'b0, out_b)
      rd_chk(`PLDAC_OFS_DUTY_B, 8'h00);
      close_out();
   end
endmodule
